// ==== dma_channel_interrupt_control.sv ====
// DMA channel interrupt control with AXI4-Lite register slave
`timescale 1ns/1ns
`default_nettype none
module dma_channel_interrupt_control
(
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [7:0]                 s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output var  logic                       s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output var  logic                       s_axi_wready,
  output var  logic [1:0]                 s_axi_bresp,
  output var  logic                       s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [7:0]                 s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output var  logic                       s_axi_arready,
  output var  logic [31:0]                s_axi_rdata,
  output var  logic [1:0]                 s_axi_rresp,
  output var  logic                       s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire dma_irq_pkg::chan_events_t  events,
  input  wire logic [31:0]                count_load,
  input  wire logic                       count_load_en,
  input  wire logic                       count_dec_en,
  output var  logic                       channel_enable,
  output var  logic                       escape_irq,
  output var  logic                       xfer_end_irq,
  output var  logic                       irq
);
  logic [31:0] ctrl;
  logic [31:0] transfer_count;
  logic [31:0] block_size;
  logic [1:0]  irq_status;
  logic [1:0]  irq_mask;
  logic [7:0]  aw_addr;
  logic        aw_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_held;

  // Write channel capture
  wire         aw_fire   = s_axi_awvalid && s_axi_awready;
  wire         w_fire    = s_axi_wvalid && s_axi_wready;
  wire         do_write  = aw_held && w_held && !s_axi_bvalid;
  wire [31:0]  strb_mask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire         wr_ctrl   = do_write && (aw_addr == dma_irq_pkg::CTRL_OFFSET);
  wire         wr_count  = do_write && (aw_addr == dma_irq_pkg::COUNT_OFFSET);
  wire         wr_block  = do_write && (aw_addr == dma_irq_pkg::BLOCK_OFFSET);
  wire         wr_stat   = do_write && (aw_addr == dma_irq_pkg::IRQ_STATUS_OFFSET);
  wire         wr_mask   = do_write && (aw_addr == dma_irq_pkg::IRQ_MASK_OFFSET);
  wire         wr_hit    = wr_ctrl || wr_count || wr_block || wr_stat || wr_mask;

  // Control field decode
  wire         size_err_en  = ctrl[dma_irq_pkg::SIZE_ERR_IE_BIT];
  wire         escape_en    = ctrl[dma_irq_pkg::ESCAPE_IE_BIT];
  wire         end_en       = ctrl[dma_irq_pkg::END_IE_BIT];
  wire         chan_en      = ctrl[dma_irq_pkg::CHANNEL_EN_BIT];
  wire         escape_flag  = ctrl[dma_irq_pkg::ESCAPE_FLAG_BIT];
  wire         counter_end_flag = ctrl[dma_irq_pkg::END_FLAG_BIT];
  wire [1:0]   access_code  = ctrl[dma_irq_pkg::ACCESS_SIZE_LSB +: 2];
  wire dma_irq_pkg::xfer_mode_t mode = dma_irq_pkg::xfer_mode_t'(ctrl[dma_irq_pkg::MODE_LSB +: 2]);

  // Bytes moved per request
  wire [31:0]  access_bytes = (access_code == 2'h0) ? 32'h00000001 :
                              (access_code == 2'h1) ? 32'h00000002 : 32'h00000004;
  wire [31:0]  unit_bytes   = (mode == dma_irq_pkg::MODE_BLOCK) ? block_size
                                                                : access_bytes;
  wire         size_short   = transfer_count < unit_bytes;
  wire         size_error   = size_err_en && chan_en && events.xfer_request
                              && size_short;

  // Flag set and clear terms; a set in the same cycle wins over a clear
  wire         escape_set   = size_error || events.repeat_size_end
                              || events.area_overflow_end;
  wire         end_set      = events.xfer_done && (transfer_count == 32'h00000000);
  wire [31:0]  wr_ctrl_val  = (ctrl & ~(dma_irq_pkg::CTRL_WRITE_MASK & strb_mask))
                              | (w_data & dma_irq_pkg::CTRL_WRITE_MASK & strb_mask);
  wire         enable_rise  = wr_ctrl && !chan_en
                              && wr_ctrl_val[dma_irq_pkg::CHANNEL_EN_BIT];
  // Flags clear by writing zero, or by starting the channel
  wire         esc_wclr     = wr_ctrl && strb_mask[dma_irq_pkg::ESCAPE_FLAG_BIT]
                              && !w_data[dma_irq_pkg::ESCAPE_FLAG_BIT];
  wire         end_wclr     = wr_ctrl && strb_mask[dma_irq_pkg::END_FLAG_BIT]
                              && !w_data[dma_irq_pkg::END_FLAG_BIT];
  wire         next_escape  = escape_set || (escape_flag && !esc_wclr && !enable_rise);
  wire         next_end     = end_set || (counter_end_flag && !end_wclr && !enable_rise);
  wire         next_chan_en = size_error ? 1'b0 : (wr_ctrl ? wr_ctrl_val[0] : chan_en);

  logic [31:0] next_ctrl;
  always_comb
  begin
    next_ctrl = wr_ctrl ? wr_ctrl_val : ctrl;
    next_ctrl[dma_irq_pkg::CHANNEL_EN_BIT] = next_chan_en;
    next_ctrl[dma_irq_pkg::ESCAPE_FLAG_BIT] = next_escape;
    next_ctrl[dma_irq_pkg::END_FLAG_BIT] = next_end;
    next_ctrl[dma_irq_pkg::RESERVED_BIT] = 1'b0;
  end

  // Interrupt request levels
  wire         next_escape_irq = escape_en && escape_flag;
  wire         next_end_irq    = end_en && counter_end_flag;
  wire [1:0]   events_seen     = {end_set, escape_set};
  wire [1:0]   next_status     = events_seen
                                 | (irq_status & ~(wr_stat ? w_data[1:0] : 2'h0));

  // Read decode
  wire         rd_fire  = s_axi_arvalid && s_axi_arready;
  wire [31:0]  rd_ctrl  = ctrl;
  wire         rd_hit   = (s_axi_araddr == dma_irq_pkg::CTRL_OFFSET)
                          || (s_axi_araddr == dma_irq_pkg::COUNT_OFFSET)
                          || (s_axi_araddr == dma_irq_pkg::BLOCK_OFFSET)
                          || (s_axi_araddr == dma_irq_pkg::IRQ_STATUS_OFFSET)
                          || (s_axi_araddr == dma_irq_pkg::IRQ_MASK_OFFSET);
  wire [31:0]  rd_value = (s_axi_araddr == dma_irq_pkg::CTRL_OFFSET)   ? rd_ctrl :
                          (s_axi_araddr == dma_irq_pkg::COUNT_OFFSET)  ? transfer_count :
                          (s_axi_araddr == dma_irq_pkg::BLOCK_OFFSET)  ? block_size :
                          (s_axi_araddr == dma_irq_pkg::IRQ_STATUS_OFFSET) ? {30'h0, irq_status} :
                          (s_axi_araddr == dma_irq_pkg::IRQ_MASK_OFFSET)   ? {30'h0, irq_mask} :
                          32'h00000000;

  // Transfer counter: load and decrement from the engine, or software write
  wire [31:0]  next_count = count_load_en ? count_load :
                            wr_count      ? ((transfer_count & ~strb_mask) | (w_data & strb_mask)) :
                            (count_dec_en && transfer_count != 32'h00000000)
                                          ? transfer_count - 32'h00000001 : transfer_count;

  // Next values of the write channel registers
  wire         next_aw_held = do_write ? 1'b0 : (aw_fire || aw_held);
  wire         next_w_held  = do_write ? 1'b0 : (w_fire || w_held);
  // Address and data are captured independently, in either order
  wire [7:0]   next_aw_addr = aw_fire ? s_axi_awaddr : aw_addr;
  wire [31:0]  next_w_data  = w_fire ? s_axi_wdata : w_data;
  wire [3:0]   next_w_strb  = w_fire ? s_axi_wstrb : w_strb;
  // Ready stays low while a write is held or answered
  wire         next_awready = !aw_held && !aw_fire && !s_axi_bvalid;
  wire         next_wready  = !w_held && !w_fire && !s_axi_bvalid;
  // Response stands until bready
  wire         next_bvalid  = do_write || (s_axi_bvalid && !s_axi_bready);
  wire [1:0]   next_bresp   = !do_write ? s_axi_bresp :
                              wr_hit    ? dma_irq_pkg::RESP_OKAY : dma_irq_pkg::RESP_SLVERR;

  // Next values of the read channel registers
  wire         next_arready = !s_axi_rvalid && !rd_fire;
  // Read data stands until rready
  wire         next_rvalid  = rd_fire || (s_axi_rvalid && !s_axi_rready);
  wire [31:0]  next_rdata   = rd_fire ? rd_value : s_axi_rdata;
  wire [1:0]   next_rresp   = !rd_fire ? s_axi_rresp :
                              rd_hit   ? dma_irq_pkg::RESP_OKAY : dma_irq_pkg::RESP_SLVERR;

  // Next values of the remaining registers
  wire [31:0]  next_block   = wr_block ? ((block_size & ~strb_mask) | (w_data & strb_mask))
                                       : block_size;
  wire [1:0]   next_mask    = wr_mask ? w_data[1:0] : irq_mask;
  // Masked status summary
  wire         next_irq     = |(next_status & irq_mask);

  // Register file
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl <= dma_irq_pkg::CTRL_RESET;
    else
      ctrl <= next_ctrl;
  end

  // Engine load beats a software write
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      transfer_count <= dma_irq_pkg::COUNT_RESET;
    else
      transfer_count <= next_count;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      block_size <= dma_irq_pkg::BLOCK_RESET;
    else
      block_size <= next_block;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_status <= dma_irq_pkg::STATUS_RESET;
    else
      irq_status <= next_status;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_mask <= dma_irq_pkg::MASK_RESET;
    else
      irq_mask <= next_mask;
  end

  // Registered outputs
  // Mirrors control bit 0, size error drops included
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      channel_enable <= 1'b0;
    else
      channel_enable <= next_chan_en;
  end

  // Requests lag the flags by one cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      escape_irq <= 1'b0;
    else
      escape_irq <= next_escape_irq;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      xfer_end_irq <= 1'b0;
    else
      xfer_end_irq <= next_end_irq;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= next_irq;
  end

  // AXI4-Lite write channel flops
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      aw_held <= 1'b0;
    else
      aw_held <= next_aw_held;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      w_held <= 1'b0;
    else
      w_held <= next_w_held;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      aw_addr <= 8'h00;
    else
      aw_addr <= next_aw_addr;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      w_data <= 32'h00000000;
    else
      w_data <= next_w_data;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      w_strb <= 4'h0;
    else
      w_strb <= next_w_strb;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_axi_awready <= 1'b0;
    else
      s_axi_awready <= next_awready;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_axi_wready <= 1'b0;
    else
      s_axi_wready <= next_wready;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_axi_bvalid <= 1'b0;
    else
      s_axi_bvalid <= next_bvalid;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_axi_bresp <= dma_irq_pkg::RESP_OKAY;
    else
      s_axi_bresp <= next_bresp;
  end

  // AXI4-Lite read channel flops
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_axi_arready <= 1'b0;
    else
      s_axi_arready <= next_arready;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_axi_rvalid <= 1'b0;
    else
      s_axi_rvalid <= next_rvalid;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_axi_rdata <= 32'h00000000;
    else
      s_axi_rdata <= next_rdata;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_axi_rresp <= dma_irq_pkg::RESP_OKAY;
    else
      s_axi_rresp <= next_rresp;
  end
endmodule
`default_nettype wire

// ==== dma_irq_pkg.sv ====
// Constants and types for the DMA channel interrupt control block
`default_nettype none
package dma_irq_pkg;
  localparam logic [7:0]  CTRL_OFFSET       = 8'h00;
  localparam logic [7:0]  COUNT_OFFSET      = 8'h04;
  localparam logic [7:0]  BLOCK_OFFSET      = 8'h08;
  localparam logic [7:0]  IRQ_STATUS_OFFSET = 8'h0C;
  localparam logic [7:0]  IRQ_MASK_OFFSET   = 8'h10;
  localparam int          ESCAPE_FLAG_BIT   = 17;
  localparam int          END_FLAG_BIT      = 16;
  localparam int          ACCESS_SIZE_LSB   = 14;
  localparam int          MODE_LSB          = 12;
  localparam int          SIZE_ERR_IE_BIT   = 11;
  localparam int          RESERVED_BIT      = 10;
  localparam int          ESCAPE_IE_BIT     = 9;
  localparam int          END_IE_BIT        = 8;
  localparam int          CHANNEL_EN_BIT    = 0;
  localparam logic [31:0] CTRL_WRITE_MASK   = 32'h0000FB01;
  localparam logic [31:0] CTRL_RESET        = 32'h00000000;
  localparam logic [31:0] COUNT_RESET       = 32'h00000000;
  localparam logic [31:0] BLOCK_RESET       = 32'h00000001;
  localparam logic [1:0]  STATUS_RESET      = 2'h0;
  localparam logic [1:0]  MASK_RESET        = 2'h0;
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

  typedef enum logic [1:0]
  {
    MODE_NORMAL = 2'b00,
    MODE_BLOCK  = 2'b01,
    MODE_REPEAT = 2'b10,
    MODE_BAD    = 2'b11
  } xfer_mode_t;

  // Channel events from the transfer engine
  typedef struct packed
  {
    logic        xfer_request;
    logic        xfer_done;
    logic        repeat_size_end;
    logic        area_overflow_end;
  } chan_events_t;
endpackage
`default_nettype wire

// ==== dma_irq_monitor.sv ====
// Port-level assertions for the DMA channel interrupt control block
`timescale 1ns/1ns
`default_nettype none
module dma_irq_monitor
(
  input wire logic                      aclk,
  input wire logic                      aresetn,
  input wire logic                      s_axi_awvalid,
  input wire logic                      s_axi_awready,
  input wire logic                      s_axi_wvalid,
  input wire logic                      s_axi_wready,
  input wire logic                      s_axi_bvalid,
  input wire logic [7:0]                s_axi_araddr,
  input wire logic                      s_axi_arvalid,
  input wire logic                      s_axi_arready,
  input wire logic [31:0]               s_axi_rdata,
  input wire logic                      s_axi_rvalid,
  input wire dma_irq_pkg::chan_events_t events,
  input wire logic                      channel_enable,
  input wire logic                      escape_irq,
  input wire logic                      xfer_end_irq
);
  logic [7:0] rd_addr;
  always_ff @(posedge aclk)
    if (s_axi_arvalid && s_axi_arready)
      rd_addr <= s_axi_araddr;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  reset_quiet_a: assert property (disable iff (1'h0) !aresetn |=>
    !escape_irq && !xfer_end_irq && !channel_enable) else $error("outputs not cleared by reset");
  write_answer_a: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write response missing");
  read_answer_a: assert property (rd_taken |-> ##[1:2] s_axi_rvalid)
    else $error("read response missing");
  reserved_zero_a: assert property (s_axi_rvalid && rd_addr == 8'h00 |-> !s_axi_rdata[10])
    else $error("reserved control bit read as one");
  size_error_a: assert property ($fell(channel_enable) |->
    $past(events.xfer_request) || s_axi_bvalid) else $error("channel enable dropped without cause");
  escape_rise_a: assert property ($rose(escape_irq) |->
    ($past(events, 2) & 4'hB) != 4'h0 || $past(s_axi_bvalid)) else $error("escape request unprovoked");
  escape_drop_a: assert property ($fell(escape_irq) |-> $past(s_axi_bvalid))
    else $error("escape request dropped without write");
  end_rise_a: assert property ($rose(xfer_end_irq) |->
    ($past(events, 2) & 4'h4) != 4'h0 || $past(s_axi_bvalid)) else $error("end request unprovoked");
  end_drop_a: assert property ($fell(xfer_end_irq) |-> $past(s_axi_bvalid))
    else $error("end request dropped without write");
endmodule
bind dma_channel_interrupt_control dma_irq_monitor mon (.*);
`default_nettype wire

// ==== cpu_irq_model.sv ====
// CPU side model that counts transfer end interrupt requests
`timescale 1ns/1ns
`default_nettype none
module cpu_irq_model
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic xfer_end_irq,
  output var int   n_end_reqs
);
  logic end_q;
  always_ff @(posedge aclk)
  begin
    end_q <= aresetn & xfer_end_irq;
    if (!aresetn)
      n_end_reqs <= 0;
    else if (xfer_end_irq && !end_q)
      n_end_reqs <= n_end_reqs + 1;
  end
endmodule
`default_nettype wire

// ==== tb.sv ====
// Register-level testbench for the DMA channel interrupt control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin n_errors++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module tb;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic s_axi_bready = 1, s_axi_rready = 1, count_load_en = 0, count_dec_en = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic channel_enable, escape_irq, xfer_end_irq, irq;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, count_load = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  dma_irq_pkg::chan_events_t events = 4'h0;
  int n_errors = 0, n_tests = 0, n_end;
  logic [23:0] rows [11] = '{24'h0A0001, 24'h0A0110, 24'h4A0101, 24'h4A0210, 24'h8A0301,
    24'h8A0410, 24'hAA0301, 24'h6A0101, 24'h1A0701, 24'h1A0810, 24'h420110};
  always #25 aclk = ~aclk;
  dma_channel_interrupt_control dut (.*);
  cpu_irq_model cpu (.aclk(aclk), .aresetn(aresetn), .xfer_end_irq(xfer_end_irq),
    .n_end_reqs(n_end));
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er = dma_irq_pkg::RESP_OKAY);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    `CHK("bresp", er, s_axi_bresp)
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ex,
    input logic [1:0] er = dma_irq_pkg::RESP_OKAY);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    `CHK("rdata", ex, s_axi_rdata)
    `CHK("rresp", er, s_axi_rresp)
  endtask
  task automatic pulse(input logic [3:0] e);
    events <= e;
    @(posedge aclk);
    events <= 4'h0;
    repeat (2) @(posedge aclk);
  endtask
  task automatic ld(input logic [31:0] c);
    count_load <= c;
    count_load_en <= 1'h1;
    @(posedge aclk);
    count_load_en <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(8'h00, 32'h0);
    rd(8'h08, 32'h1);
    rd(8'h20, 32'h0, dma_irq_pkg::RESP_SLVERR);
    wr(8'h20, 32'hFFFFFFFF, dma_irq_pkg::RESP_SLVERR);
    wr(8'h00, 32'hFFFFFFFF);
    rd(8'h00, 32'h0000FB01);
    `CHK("chan_en", 1'h1, channel_enable)
    $display("test reset and access done");
    wr(8'h00, 32'h101);
    ld(32'h1);
    count_dec_en <= 1'h1;
    @(posedge aclk);
    count_dec_en <= 1'h0;
    pulse(4'h4);
    `CHK("end_irq", 1'h1, xfer_end_irq)
    rd(8'h00, 32'h10101);
    wr(8'h00, 32'h10001);
    `CHK("end_irq", 1'h0, xfer_end_irq)
    wr(8'h00, 32'h10101);
    `CHK("end_irq", 1'h1, xfer_end_irq)
    wr(8'h00, 32'h101);
    `CHK("end_irq", 1'h0, xfer_end_irq)
    `CHK("cpu_reqs", 2, n_end)
    $display("test transfer end done");
    `CHK("irq", 1'h0, irq)
    wr(8'h10, 32'h3);
    `CHK("irq", 1'h1, irq)
    wr(8'h0C, 32'h3);
    `CHK("irq", 1'h0, irq)
    rd(8'h0C, 32'h0);
    $display("test status and mask done");
    s_axi_wstrb <= 4'h2;
    wr(8'h08, 32'h0000FF77);
    s_axi_wstrb <= 4'hF;
    rd(8'h08, 32'h0000FF01);
    wr(8'h08, 32'h8);
    foreach (rows[i])
    begin
      ld({24'h0, rows[i][15:8]});
      wr(8'h00, {16'h0, rows[i][23:16], 8'h01});
      pulse(4'h8);
      `CHK("chan_en", rows[i][4], channel_enable)
      `CHK("esc_irq", rows[i][0], escape_irq)
    end
    $display("test size error done");
    for (int k = 0; k < 2; k++)
    begin
      wr(8'h00, 32'h201);
      pulse(4'h1 << k);
      `CHK("esc_irq", 1'h1, escape_irq)
      rd(8'h00, 32'h20201);
    end
    wr(8'h00, 32'h20001);
    `CHK("esc_irq", 1'h0, escape_irq)
    $display("test escape sources done");
    tally_and_finish;
  end
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    $display("watchdog expired");
    tally_and_finish;
  end
endmodule
`default_nettype wire
